// ===== timer16_event_window_counter.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "timer16_consts.svh"
module timer16_event_window_counter
    import timer16_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // axi4-lite write address and data
    input wire logic [`ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external count or window pin
    input wire logic count_input_pin,
    // power mode and clock context
    input wire logic low_freq_tick,
    input wire logic low_speed_mode_two,
    input wire logic stop_entry,
    input wire logic prescaler_tap_select,
    // match event
    output logic match_interrupt
);
    if (CNT_W != 16) begin : g_bad_width
        $error("compare register is two bytes, CNT_W must be 16");
    end

    pin_edge_if pin_edges ();

    pin_edge_sync u_pin_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(count_input_pin),
        .edges(pin_edges)
    );

    // bus and register state
    logic aw_got_ff;
    logic nxt_aw_got;
    logic [`ADDR_W-1:0] awaddr_ff;
    logic [`ADDR_W-1:0] nxt_awaddr;
    logic w_got_ff;
    logic nxt_w_got;
    logic [7:0] wdata_ff;
    logic [7:0] nxt_wdata;
    logic wstrb0_ff;
    logic nxt_wstrb0;
    logic bvalid_ff;
    logic nxt_bvalid;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] rresp_ff;
    logic [1:0] nxt_rresp;
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [7:0] cmp_lo_ff;
    logic [7:0] nxt_cmp_lo;
    logic [CNT_W-1:0] cmp_ff;
    logic [CNT_W-1:0] nxt_cmp;
    logic pend_ff;
    logic nxt_pend;
    // counter state
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [`PRE_W-1:0] pre_ff;
    logic [`PRE_W-1:0] nxt_pre;
    logic [`LF_DIV_W-1:0] lf_div_ff;
    logic [`LF_DIV_W-1:0] nxt_lf_div;
    logic irq_ff;
    logic nxt_irq;
    // decode
    logic wr_fire;
    logic [2:0] ck_sel;
    mode_t mode;
    logic run;
    logic warm_sel;
    logic int_tick;
    logic [CNT_W-1:0] cnt_inc;

    function automatic mode_t mode_of(input logic [7:0] c);
        if (c[`CTRL_CK_MSB:`CTRL_CK_LSB] == `CK_EXT) begin
            return MODE_EVENT;
        end else if (c[`CTRL_MODE_BIT]) begin
            return MODE_WINDOW;
        end
        return MODE_TIMER;
    endfunction

    // low n bits of the prescaler all ones: one tick every 2^n clocks
    function automatic logic pre_tap(input logic [`PRE_W-1:0] p, input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < `PRE_W; i++) begin
            if (i < n) begin
                r = r & p[i];
            end
        end
        return r;
    endfunction

    function automatic logic is_match(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] k,
                                      input logic warm);
        if (warm) begin
            return c[CNT_W-1:`WARM_LSB] == k[CNT_W-1:`WARM_LSB];
        end
        return c == k;
    endfunction

    assign ck_sel = ctrl_ff[`CTRL_CK_MSB:`CTRL_CK_LSB];
    assign mode = mode_of(ctrl_ff);
    assign run = ctrl_ff[`CTRL_RUN_BIT];
    assign warm_sel = low_speed_mode_two && (ck_sel == `CK_FC) && (mode == MODE_TIMER);
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    assign cnt_inc = CNT_W'(cnt_ff + 1'b1);

    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign match_interrupt = irq_ff;

    // register bus: address and data taken in either order, answer after both
    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_got = w_got_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb0 = wstrb0_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_cmp_lo = cmp_lo_ff;
        nxt_cmp = cmp_ff;
        nxt_pend = pend_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_axi_wdata[7:0];
            nxt_wstrb0 = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = `RESP_OKAY;
            case (awaddr_ff)
                `OFF_CTRL: begin
                    if (wstrb0_ff) begin
                        nxt_ctrl = wdata_ff & `CTRL_WR_MASK;
                    end
                end
                `OFF_CMP_LO: begin
                    if (wstrb0_ff) begin
                        nxt_cmp_lo = wdata_ff;
                        nxt_pend = 1'b1;
                    end
                end
                `OFF_CMP_HI: begin
                    if (wstrb0_ff && pend_ff) begin
                        nxt_cmp = {wdata_ff, cmp_lo_ff};
                        nxt_pend = 1'b0;
                    end else if (wstrb0_ff && warm_sel) begin
                        nxt_cmp = {wdata_ff, cmp_ff[7:0]};
                    end
                end
                `OFF_STATUS: begin
                    nxt_bresp = `RESP_OKAY;
                end
                default: begin
                    nxt_bresp = `RESP_SLVERR;
                end
            endcase
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        // stop power mode halts the counter, overriding a same-cycle write
        if (stop_entry) begin
            nxt_ctrl[`CTRL_RUN_BIT] = 1'b0;
        end
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = `RESP_OKAY;
            case (s_axi_araddr)
                `OFF_CTRL: nxt_rdata = {24'h00_0000, ctrl_ff & `CTRL_WR_MASK};
                `OFF_CMP_LO: nxt_rdata = {24'h00_0000, cmp_ff[7:0]};
                `OFF_CMP_HI: nxt_rdata = {24'h00_0000, cmp_ff[CNT_W-1:8]};
                `OFF_STATUS: begin
                    nxt_rdata = {{(32 - CNT_W){1'b0}}, cnt_ff};
                    nxt_rdata[`STAT_PEND_BIT] = pend_ff;
                    nxt_rdata[`STAT_WARM_BIT] = warm_sel;
                end
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = `RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            w_got_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RESP_OKAY;
            ctrl_ff <= `CTRL_RST;
            cmp_lo_ff <= `CMP_LO_RST;
            cmp_ff <= `CMP_RST;
            pend_ff <= 1'b0;
        end else begin
            aw_got_ff <= nxt_aw_got;
            awaddr_ff <= nxt_awaddr;
            w_got_ff <= nxt_w_got;
            wdata_ff <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            ctrl_ff <= nxt_ctrl;
            cmp_lo_ff <= nxt_cmp_lo;
            cmp_ff <= nxt_cmp;
            pend_ff <= nxt_pend;
        end
    end

    // counting: tick selection, mode handling and match
    always_comb begin
        nxt_pre = `PRE_W'(pre_ff + 1'b1);
        nxt_lf_div = low_freq_tick ? `LF_DIV_W'(lf_div_ff + 1'b1) : lf_div_ff;
        nxt_cnt = cnt_ff;
        nxt_irq = 1'b0;
        case (ck_sel)
            `CK_DIV11: int_tick = prescaler_tap_select ? (low_freq_tick && &lf_div_ff) : pre_tap(pre_ff, `TAP_DIV11);
            `CK_DIV7: int_tick = pre_tap(pre_ff, `TAP_DIV7);
            `CK_DIV5: int_tick = pre_tap(pre_ff, `TAP_DIV5);
            `CK_DIV3: int_tick = pre_tap(pre_ff, `TAP_DIV3);
            `CK_LF: int_tick = low_freq_tick;
            `CK_DIV1: int_tick = pre_tap(pre_ff, `TAP_DIV1);
            `CK_FC: int_tick = warm_sel;
            default: int_tick = 1'b0;
        endcase
        if (!run) begin
            nxt_cnt = '0;
        end else if (mode == MODE_EVENT) begin
            if (pin_edges.rise) begin
                nxt_cnt = cnt_inc;
            end
            if (pin_edges.fall && is_match(cnt_ff, cmp_ff, 1'b0)) begin
                nxt_cnt = '0;
                nxt_irq = 1'b1;
            end
        end else if (int_tick && (mode == MODE_TIMER || pin_edges.level)) begin
            if (is_match(cnt_inc, cmp_ff, warm_sel)) begin
                nxt_cnt = '0;
                nxt_irq = 1'b1;
            end else begin
                nxt_cnt = cnt_inc;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
            pre_ff <= '0;
            lf_div_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            pre_ff <= nxt_pre;
            lf_div_ff <= nxt_lf_div;
            irq_ff <= nxt_irq;
        end
    end

    property p_irq_single;
        @(posedge ref_clk) disable iff (rst)
        irq_ff |=> !irq_ff;
    endproperty
    a_irq_single: assert property (p_irq_single) else $error("match pulse longer than one cycle");

    property p_pair_commit;
        @(posedge ref_clk) disable iff (rst)
        wr_fire && awaddr_ff == `OFF_CMP_HI && wstrb0_ff && pend_ff
        |=> cmp_ff == {$past(wdata_ff), $past(cmp_lo_ff)} && !pend_ff;
    endproperty
    a_pair_commit: assert property (p_pair_commit) else $error("high byte did not commit pair");

    property p_low_holds;
        @(posedge ref_clk) disable iff (rst)
        wr_fire && awaddr_ff == `OFF_CMP_LO |=> cmp_ff == $past(cmp_ff);
    endproperty
    a_low_holds: assert property (p_low_holds) else $error("low byte changed live compare");

    property p_stop_halts;
        @(posedge ref_clk) disable iff (rst)
        stop_entry |=> !ctrl_ff[`CTRL_RUN_BIT] ##1 cnt_ff == '0;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("stop entry left counter running");

    property p_event_on_fall;
        @(posedge ref_clk) disable iff (rst)
        irq_ff && $past(mode) == MODE_EVENT |-> $past(pin_edges.fall) && cnt_ff == '0;
    endproperty
    a_event_on_fall: assert property (p_event_on_fall) else $error("event match not on falling edge");

    property p_window_gate;
        @(posedge ref_clk) disable iff (rst)
        run && mode == MODE_WINDOW && !pin_edges.level |=> cnt_ff == $past(cnt_ff) && !irq_ff;
    endproperty
    a_window_gate: assert property (p_window_gate) else $error("window counted with pin low");

    property p_timer_clear;
        @(posedge ref_clk) disable iff (rst)
        run && mode == MODE_TIMER && int_tick && !warm_sel && cnt_inc == cmp_ff |=> irq_ff && cnt_ff == '0;
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("timer match did not clear and pulse");

    property p_fc_only_low_speed_mode_two;
        @(posedge ref_clk) disable iff (rst)
        run && ck_sel == `CK_FC && !low_speed_mode_two |=> cnt_ff == $past(cnt_ff);
    endproperty
    a_fc_only_low_speed_mode_two: assert property (p_fc_only_low_speed_mode_two) else $error("fast clock counted outside mode two");

    property p_ctrl_read;
        @(posedge ref_clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_CTRL
        |=> s_axi_rvalid && s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[1] == 1'b0;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read showed undefined bits");
endmodule

// ===== timer16_consts.svh
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH
`define ADDR_W 8
`define OFF_CTRL 8'h00
`define OFF_CMP_LO 8'h04
`define OFF_CMP_HI 8'h08
`define OFF_STATUS 8'h0C
`define CTRL_MODE_BIT 0
`define CTRL_CK_LSB 2
`define CTRL_CK_MSB 4
`define CTRL_RUN_BIT 5
`define CTRL_WR_MASK 8'h3D
`define CTRL_RST 8'h00
`define CMP_RST 16'hFFFF
`define CMP_LO_RST 8'hFF
`define STAT_PEND_BIT 16
`define STAT_WARM_BIT 17
`define CK_DIV11 3'h0
`define CK_DIV7 3'h1
`define CK_DIV5 3'h2
`define CK_DIV3 3'h3
`define CK_LF 3'h4
`define CK_DIV1 3'h5
`define CK_FC 3'h6
`define CK_EXT 3'h7
`define PRE_W 11
`define TAP_DIV11 11
`define TAP_DIV7 7
`define TAP_DIV5 5
`define TAP_DIV3 3
`define TAP_DIV1 1
`define LF_DIV_W 3
`define WARM_LSB 11
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== timer16_pkg.sv
package timer16_pkg;
    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_EVENT,
        MODE_WINDOW
    } mode_t;
endpackage

// ===== pin_edge_if.sv
`timescale 1ns/1ns
interface pin_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// ===== pin_edge_sync.sv
`timescale 1ns/1ns
module pin_edge_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // raw pin and cleaned result
    input wire logic pin_in,
    pin_edge_if.src edges
);
    logic [2:0] sync_ff;
    logic [2:0] nxt_sync;
    logic level_ff;
    logic nxt_level;
    logic rise_ff;
    logic nxt_rise;
    logic fall_ff;
    logic nxt_fall;
    logic agree;

    // a change counts once the second and third stages agree
    always_comb begin
        nxt_sync = {sync_ff[1:0], pin_in};
        agree = (sync_ff[1] == sync_ff[2]);
        nxt_level = agree ? sync_ff[2] : level_ff;
        nxt_rise = agree && sync_ff[2] && !level_ff;
        nxt_fall = agree && !sync_ff[2] && level_ff;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_ff <= 3'h0;
            level_ff <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else begin
            sync_ff <= nxt_sync;
            level_ff <= nxt_level;
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
        end
    end

    assign edges.level = level_ff;
    assign edges.rise = rise_ff;
    assign edges.fall = fall_ff;
endmodule

// ===== count_pin_source.sv
`timescale 1ns/1ns
module count_pin_source (
    // clock
    input wire logic ref_clk,
    // pin toward the counter
    output logic pin
);
    initial pin = 1'b0;
    // each level stands w cycles, never fewer than two
    task automatic pulses(input int n, input int w);
        for (int i = 0; i < n; i++) begin
            repeat (w) @(posedge ref_clk);
            pin <= 1'b1;
            repeat (w) @(posedge ref_clk);
            pin <= 1'b0;
        end
        repeat (w + 6) @(posedge ref_clk);
    endtask
    // window level is held for many count ticks
    task automatic hold(input logic v, input int cyc);
        @(posedge ref_clk);
        pin <= v;
        repeat (cyc) @(posedge ref_clk);
    endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ns
`include "timer16_consts.svh"
module tb_top;
    logic ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pin, lf_tick, lsm2, stop_entry, tap, irq;
    logic [7:0] awaddr, araddr, m_ctrl, m_lo;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] m_cmp;
    logic m_pend;
    int err_count, checks, cyc, irq_cnt, irq_last, irq_prev, lf_div, c, p, n0;
    int per[7] = '{2, 8, 32, 128, 5, 40, 2048};
    int sel[7] = '{5, 3, 2, 1, 4, 0, 0};

    timer16_event_window_counter #(.CNT_W(16)) i_dut (
        .ref_clk(ref_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .count_input_pin(pin), .low_freq_tick(lf_tick), .low_speed_mode_two(lsm2),
        .stop_entry(stop_entry), .prescaler_tap_select(tap), .match_interrupt(irq)
    );
    count_pin_source i_pin (.ref_clk(ref_clk), .pin(pin));

    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;
    // slow clock strobe, one every five system cycles
    always @(posedge ref_clk) begin
        lf_div <= (lf_div == 4) ? 0 : lf_div + 1;
        lf_tick <= (lf_div == 4);
    end
    always @(negedge ref_clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            irq_prev <= irq_last;
            irq_last <= cyc;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [1:0] model_wr(input logic [7:0] a, input logic [7:0] v);
        logic warm;
        warm = (m_ctrl[4:2] == 3'h6) && !m_ctrl[0] && lsm2;
        // a write with byte lane 0 off leaves every register alone
        if (!wstrb[0]) return `RESP_OKAY;
        case (a)
            `OFF_CTRL: m_ctrl = v & `CTRL_WR_MASK;
            `OFF_CMP_LO: begin
                m_lo = v;
                m_pend = 1'b1;
            end
            `OFF_CMP_HI: begin
                if (m_pend) m_cmp = {v, m_lo};
                else if (warm) m_cmp[15:8] = v;
                m_pend = 1'b0;
            end
            `OFF_STATUS: ;
            default: return `RESP_SLVERR;
        endcase
        return `RESP_OKAY;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic ah, wh, hs, ad, wd;
        logic [1:0] er;
        @(posedge ref_clk);
        er = model_wr(a, v);
        awaddr <= a;
        wdata <= {24'h00_0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        ad = 1'b0;
        wd = 1'b0;
        while (!(ad && wd)) begin
            @(negedge ref_clk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            @(posedge ref_clk);
            if (ah) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (wh) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        bready <= 1'b1;
        hs = 1'b0;
        while (!hs) begin
            @(negedge ref_clk);
            hs = bvalid;
            r = bresp;
            @(posedge ref_clk);
        end
        bready <= 1'b0;
        chk(r, er);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ah, hs;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hs = 1'b0;
        while (!hs) begin
            @(negedge ref_clk);
            ah = arvalid && arready;
            hs = rvalid;
            d = rdata;
            r = rresp;
            @(posedge ref_clk);
            if (ah) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] mask);
        logic [31:0] e;
        e = (a == `OFF_CTRL) ? m_ctrl : (a == `OFF_CMP_LO) ? m_cmp[7:0] : (a == `OFF_CMP_HI) ? m_cmp[15:8] : 0;
        rd(a);
        chk(d & mask, e & mask);
        chk(r, (a > `OFF_STATUS) ? `RESP_SLVERR : `RESP_OKAY);
    endtask
    task automatic wait_irqs(input int n);
        int s;
        s = irq_cnt;
        for (int k = 0; k < 20000 && irq_cnt < s + n; k++) @(posedge ref_clk);
    endtask
    task automatic set_cmp(input logic [15:0] v);
        wr(`OFF_CMP_LO, v[7:0]);
        wr(`OFF_CMP_HI, v[15:8]);
    endtask

    initial begin
        #(100000 * 8);
        err_count++;
        give_verdict();
    end
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, lsm2, stop_entry, tap} = 9'h1_00;
        {awaddr, araddr, wdata, lf_div, cyc, irq_cnt, irq_last, irq_prev} = '0;
        wstrb = 4'hF;
        m_ctrl = `CTRL_RST;
        m_cmp = `CMP_RST;
        m_lo = `CMP_LO_RST;
        m_pend = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        void'($urandom(57863));
        rchk(`OFF_CTRL, 32'h0000_003D);
        rchk(`OFF_CMP_LO, 32'hFFFF_FFFF);
        rchk(`OFF_CMP_HI, 32'hFFFF_FFFF);
        rchk(8'h10, 32'hFFFF_FFFF);
        wr(8'h14, 8'h5A);
        wr(`OFF_STATUS, 8'hA5);
        wstrb <= 4'hE;
        wr(`OFF_CTRL, 8'h15);
        wstrb <= 4'hF;
        rchk(`OFF_CTRL, 32'h0000_003D);
        $display("test registers done");
        wr(`OFF_CMP_LO, 8'($urandom));
        rchk(`OFF_CMP_LO, 32'hFFFF_FFFF);
        rd(`OFF_STATUS);
        chk(d[`STAT_PEND_BIT], 1'b1);
        wr(`OFF_CMP_LO, 8'($urandom));
        wr(`OFF_CMP_HI, 8'($urandom));
        rchk(`OFF_CMP_LO, 32'hFFFF_FFFF);
        wr(`OFF_CMP_HI, 8'($urandom));
        rchk(`OFF_CMP_HI, 32'hFFFF_FFFF);
        $display("test compare pairing done");
        c = 2 + $urandom % 2;
        set_cmp(16'(c));
        for (int i = 0; i < 7; i++) begin
            wr(`OFF_CTRL, 8'(sel[i] << 2));
            tap <= (i == 5);
            wr(`OFF_CTRL, 8'(sel[i] << 2) | 8'h20);
            wait_irqs(3);
            chk(32'(irq_last - irq_prev), 32'(per[i] * c));
        end
        $display("test timer clocks done");
        @(posedge ref_clk) stop_entry <= 1'b1;
        @(posedge ref_clk) stop_entry <= 1'b0;
        m_ctrl[5] = 1'b0;
        rchk(`OFF_CTRL, 32'h0000_003D);
        rd(`OFF_STATUS);
        chk(d[15:0], 16'h0000);
        $display("test stop entry done");
        wr(`OFF_CTRL, 8'h15);
        i_pin.hold(1'b1, 20);
        wr(`OFF_CTRL, 8'h35);
        wait_irqs(3);
        chk(32'(irq_last - irq_prev), 32'(2 * c));
        i_pin.hold(1'b0, 10);
        n0 = irq_cnt;
        i_pin.hold(1'b0, 300);
        chk(32'(irq_cnt), 32'(n0));
        wr(`OFF_CTRL, 8'h14);
        $display("test window done");
        c = 2 + $urandom % 6;
        p = 10 + $urandom % 10;
        set_cmp(16'(c));
        wr(`OFF_CTRL, 8'h1C);
        wr(`OFF_CTRL, 8'h3C);
        n0 = irq_cnt;
        i_pin.pulses(p, 3 + $urandom % 4);
        chk(32'(irq_cnt - n0), 32'(p / c));
        rd(`OFF_STATUS);
        chk(d[15:0], 16'(p % c));
        $display("test event done");
        wr(`OFF_CTRL, 8'h00);
        lsm2 <= 1'b1;
        wr(`OFF_CTRL, 8'h18);
        wr(`OFF_CMP_HI, 8'h10);
        rchk(`OFF_CMP_HI, 32'hFFFF_FFFF);
        wr(`OFF_CTRL, 8'h38);
        wait_irqs(3);
        chk(32'(irq_last - irq_prev), 32'h0000_1000);
        rd(`OFF_STATUS);
        chk(d[`STAT_WARM_BIT], 1'b1);
        lsm2 <= 1'b0;
        repeat (10) @(posedge ref_clk);
        n0 = irq_cnt;
        repeat (4200) @(posedge ref_clk);
        chk(32'(irq_cnt), 32'(n0));
        $display("test warm-up done");
        give_verdict();
    end
endmodule
